// [core/index_port_defs.svh]
// offsets, field positions and index map constants for the indexed register port
`ifndef INDEX_PORT_DEFS_SVH
`define INDEX_PORT_DEFS_SVH
// ************************************************************
// host i/o addresses
// ************************************************************
`define IDX_ADDR_POINTER 10'h3e0
`define IDX_ADDR_WINDOW 10'h3e1
// ************************************************************
// pointer fields and reset
// ************************************************************
`define IDX_DEV_BIT 7
`define IDX_SOCK_BIT 6
`define IDX_REG_MSB 5
`define IDX_POINTER_RESET 8'h00
// ************************************************************
// index map, first socket numbers
// ************************************************************
`define IDX_CHIP_REV 6'h00
`define IDX_IF_STATUS 6'h01
`define IDX_PWR_CTRL 6'h02
`define IDX_INT_GEN_CTRL 6'h03
`define IDX_CARD_STAT_CHG 6'h04
`define IDX_MGMT_INT_CFG 6'h05
`define IDX_MAP_ENABLE 6'h06
`define IDX_IO_WIN_CTRL 6'h07
`define IDX_IO_WIN_FIRST 6'h08
`define IDX_IO_WIN_LAST 6'h0f
`define IDX_MEM_WIN0 6'h10
`define IDX_MEM_WIN1 6'h18
`define IDX_MEM_WIN2 6'h20
`define IDX_MEM_WIN3 6'h28
`define IDX_MEM_WIN_SPAN 6'h06
`define IDX_MISC_CTRL1 6'h16
`define IDX_FIFO_CTRL 6'h17
`define IDX_MISC_CTRL2 6'h1e
`define IDX_CHIP_INFO 6'h1f
`define IDX_ATA_CTRL 6'h26
`define IDX_SCRATCH 6'h27
`endif

// [core/index_port_pkg.sv]
// types for the indexed register port
package index_port_pkg;
   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_SOCKET = 2'b01,
      SEL_CHIP = 2'b10
   } loc_kind_t;
endpackage

// [core/indexed_register_access_port.sv]
// indexed register access port: pointer at one i/o address, window at the next
//
// Operation
// - pointer at 3e0h, data window at 3e1h
// - pointer bits 5:0 pick register number
// - pointer bit 6 picks socket
// - bit 7 must match own device number
// - data access uses current pointer value
// - 128 locations, 64 per socket
// - 00h-3fh socket one, 40h-7fh socket two
// - pointer read back only on device zero
// - device one 16-bit read: upper byte data
// - revision, misc two, info are chip-wide
// - 02h-07h socket control registers
// - 08h-0fh i/o window start/end addresses
// - memory windows six bytes from 10h/18h/20h/28h
// - 16h,17h,26h,27h misc, fifo, ata, scratch
// - socket two register at index plus 40h
// - pointer clears when power good cycles
`timescale 1ns/1ns
`include "index_port_defs.svh"
module indexed_register_access_port
   import index_port_pkg::*;
#(
   parameter logic DEVICE_NUMBER = 1'b0,
   parameter logic [7:0] CHIP_REV_VALUE = 8'h00, // arbitrary value
   parameter logic [7:0] CHIP_INFO_VALUE = 8'h00 // arbitrary value
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic power_ok_input,
   input wire logic [9:0] io_addr,
   input wire logic io_read,
   input wire logic io_write,
   input wire logic io_wide,
   input wire logic [7:0] io_wdata,
   output logic [15:0] io_rdata,
   output logic io_rdata_low_oe,
   output logic io_rdata_high_oe
);
   // ************************************************************
   // state
   // ************************************************************
   logic [7:0] pointer;
   logic [7:0] next_pointer;
   // window bytes, not reset: unknown until the host writes them
   logic [7:0] store [0:255];
   logic [15:0] next_rdata;
   logic next_low_oe;
   logic next_high_oe;
   logic [7:0] loc;
   loc_kind_t kind;
   logic hit_ptr;
   logic hit_win;
   logic dev_match;

   // classify a six bit register number
   function automatic loc_kind_t classify(input logic [5:0] n);
      loc_kind_t k;
      k = SEL_NONE;
      if (n == `IDX_CHIP_REV || n == `IDX_MISC_CTRL2 || n == `IDX_CHIP_INFO) begin
         k = SEL_CHIP;
      end else if (n >= `IDX_PWR_CTRL && n <= `IDX_IO_WIN_CTRL) begin
         k = SEL_SOCKET;
      end else if (n >= `IDX_IO_WIN_FIRST && n <= `IDX_IO_WIN_LAST) begin
         k = SEL_SOCKET;
      end else if ((n >= `IDX_MEM_WIN0 && n < `IDX_MEM_WIN0 + `IDX_MEM_WIN_SPAN)
                || (n >= `IDX_MEM_WIN1 && n < `IDX_MEM_WIN1 + `IDX_MEM_WIN_SPAN)
                || (n >= `IDX_MEM_WIN2 && n < `IDX_MEM_WIN2 + `IDX_MEM_WIN_SPAN)
                || (n >= `IDX_MEM_WIN3 && n < `IDX_MEM_WIN3 + `IDX_MEM_WIN_SPAN)) begin
         k = SEL_SOCKET;
      end else if (n == `IDX_MISC_CTRL1 || n == `IDX_FIFO_CTRL || n == `IDX_ATA_CTRL
                || n == `IDX_SCRATCH) begin
         k = SEL_SOCKET;
      end
      return k;
   endfunction

   // ************************************************************
   // decode
   // ************************************************************
   // address decode
   assign hit_ptr = (io_addr == `IDX_ADDR_POINTER);
   assign hit_win = (io_addr == `IDX_ADDR_WINDOW);
   assign dev_match = (pointer[`IDX_DEV_BIT] == DEVICE_NUMBER);
   assign kind = classify(pointer[`IDX_REG_MSB:0]);
   // socket bit forms upper part of location, except on chip-wide registers
   assign loc = (kind == SEL_CHIP) ? {2'b00, pointer[`IDX_REG_MSB:0]}
                                   : {1'b0, pointer[`IDX_SOCK_BIT], pointer[`IDX_REG_MSB:0]};

   // ************************************************************
   // pointer register
   // ************************************************************
   // host write to the pointer
   always_comb begin
      next_pointer = pointer;
      if (io_write && hit_ptr) begin
         next_pointer = io_wdata;
      end
   end

   // cleared by reset or power good low
   always_ff @(posedge clock) begin
      if (!rst_n || !power_ok_input) begin
         pointer <= `IDX_POINTER_RESET;
      end else begin
         pointer <= next_pointer;
      end
   end

   // window write stores only defined locations
   always_ff @(posedge clock) begin
      if (io_write && hit_win && dev_match && kind != SEL_NONE) begin
         store[loc] <= io_wdata;
      end
   end

   // ************************************************************
   // read path
   // ************************************************************
   always_comb begin
      logic [7:0] win;
      win = 8'h00;
      next_rdata = 16'h0000;
      next_low_oe = 1'b0;
      next_high_oe = 1'b0;
      if (kind == SEL_CHIP && pointer[`IDX_REG_MSB:0] == `IDX_CHIP_REV) begin
         win = CHIP_REV_VALUE;
      end else if (kind == SEL_CHIP && pointer[`IDX_REG_MSB:0] == `IDX_CHIP_INFO) begin
         win = CHIP_INFO_VALUE;
      end else if (kind != SEL_NONE) begin
         win = store[loc];
      end
      if (io_read && hit_ptr) begin
         // pointer read back on device zero
         if (DEVICE_NUMBER == 1'b0) begin
            next_low_oe = 1'b1;
            next_high_oe = io_wide && dev_match;
            // upper byte stays zero unless it is driven
            next_rdata = {next_high_oe ? win : 8'h00, pointer};
         // device one drives upper byte only
         end else if (io_wide && dev_match) begin
            next_rdata = {win, 8'h00};
            next_high_oe = 1'b1;
         end
      end else if (io_read && hit_win && dev_match) begin
         next_rdata = {8'h00, win};
         next_low_oe = 1'b1;
      end
   end

   // register the read answer and its drive enables
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         io_rdata <= 16'h0000;
         io_rdata_low_oe <= 1'b0;
         io_rdata_high_oe <= 1'b0;
      end else begin
         io_rdata <= next_rdata;
         io_rdata_low_oe <= next_low_oe;
         io_rdata_high_oe <= next_high_oe;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   // pointer, window and location map checks
   a_pointer_write_taken: assert property (@(posedge clock) disable iff (!rst_n)
      io_write && hit_ptr && power_ok_input |=> pointer == $past(io_wdata))
      else $error("pointer write lost");
   a_power_clears_pointer: assert property (@(posedge clock) disable iff (!rst_n)
      !power_ok_input |=> pointer == 8'h00)
      else $error("pointer not cleared");
   a_dev_one_no_low: assert property (@(posedge clock) disable iff (!rst_n)
      io_read && hit_ptr && DEVICE_NUMBER == 1'b1 |=> !io_rdata_low_oe)
      else $error("device one drove pointer");
   a_dev_one_high: assert property (@(posedge clock) disable iff (!rst_n)
      io_read && hit_ptr && io_wide && dev_match && DEVICE_NUMBER == 1'b1 |=> io_rdata_high_oe)
      else $error("device one upper byte missing");
   a_foreign_silent: assert property (@(posedge clock) disable iff (!rst_n)
      io_read && hit_win && !dev_match |=> !io_rdata_low_oe && !io_rdata_high_oe)
      else $error("answered other device");
   a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
      io_read && hit_win && dev_match && kind == SEL_NONE |=> io_rdata == 16'h0000 && io_rdata_low_oe)
      else $error("reserved read not zero");
   a_window_roundtrip: assert property (@(posedge clock) disable iff (!rst_n)
      io_write && hit_win && dev_match && kind == SEL_SOCKET ##1 io_read && hit_win && $stable(pointer)
      |=> io_rdata[7:0] == $past(io_wdata, 2))
      else $error("window data mismatch");
   a_chip_wide: assert property (@(posedge clock) disable iff (!rst_n)
      kind == SEL_CHIP |-> loc[7:6] == 2'b00)
      else $error("chip register split per socket");
   a_socket_offset: assert property (@(posedge clock) disable iff (!rst_n)
      kind == SEL_SOCKET && pointer[`IDX_SOCK_BIT] |-> loc == {2'b01, pointer[5:0]})
      else $error("socket two offset wrong");

   // read answer shape and pointer retention
   a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      !(io_read && (hit_ptr || hit_win)) |=> !io_rdata_low_oe && !io_rdata_high_oe)
      else $error("answer without decoded read");
   a_dev_zero_readback: assert property (@(posedge clock) disable iff (!rst_n)
      io_read && hit_ptr && DEVICE_NUMBER == 1'b0 |=> io_rdata_low_oe && io_rdata[7:0] == $past(pointer))
      else $error("pointer read back wrong");
   a_pointer_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !(io_write && hit_ptr) && power_ok_input |=> $stable(pointer))
      else $error("pointer changed without write");
   a_narrow_high_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      io_read && hit_ptr && !io_wide |=> !io_rdata_high_oe && io_rdata[15:8] == 8'h00)
      else $error("upper byte on narrow read");
   a_chip_rev_read: assert property (@(posedge clock) disable iff (!rst_n)
      io_read && hit_win && dev_match && kind == SEL_CHIP && pointer[`IDX_REG_MSB:0] == `IDX_CHIP_REV
      |=> io_rdata[7:0] == CHIP_REV_VALUE)
      else $error("revision read wrong");
endmodule // indexed_register_access_port

// [tb/indexed_register_access_port_test.sv]
// testbench for the indexed register access port, two devices on one bus
`timescale 1ns/1ns
module indexed_register_access_port_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic power_ok_input = 1'b1;
   logic [9:0] io_addr;
   logic io_read, io_write, io_wide;
   logic [7:0] io_wdata;
   logic [15:0] rdata0, rdata1;
   logic lo0, hi0, lo1, hi1;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   always #50 clock = ~clock;
   io_host_model io_host_model_i (.clock(clock), .io_addr(io_addr), .io_read(io_read), .io_write(io_write),
      .io_wide(io_wide), .io_wdata(io_wdata));
   // chip revision and info values are arbitrary
   indexed_register_access_port #(.DEVICE_NUMBER(1'b0), .CHIP_REV_VALUE(8'h11), .CHIP_INFO_VALUE(8'h22))
      indexed_register_access_port_i (.clock(clock), .rst_n(rst_n), .power_ok_input(power_ok_input),
      .io_addr(io_addr), .io_read(io_read), .io_write(io_write), .io_wide(io_wide), .io_wdata(io_wdata),
      .io_rdata(rdata0), .io_rdata_low_oe(lo0), .io_rdata_high_oe(hi0));
   indexed_register_access_port #(.DEVICE_NUMBER(1'b1))
      indexed_register_access_port_i1 (.clock(clock), .rst_n(rst_n), .power_ok_input(power_ok_input),
      .io_addr(io_addr), .io_read(io_read), .io_write(io_write), .io_wide(io_wide), .io_wdata(io_wdata),
      .io_rdata(rdata1), .io_rdata_low_oe(lo1), .io_rdata_high_oe(hi1));
   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // read, then judge data and enables of both devices
   task automatic rd_chk(input logic win, input logic wide, input logic [15:0] e0, input logic [1:0] oe0,
      input logic [15:0] e1, input logic [1:0] oe1);
      io_host_model_i.rd(win, wide);
      chk(rdata0, e0);
      chk({14'h0, hi0, lo0}, {14'h0, oe0});
      chk(rdata1, e1);
      chk({14'h0, hi1, lo1}, {14'h0, oe1});
   endtask
   // every defined socket byte, both sockets, written back to back then read
   // host programs only defined register numbers here
   task automatic t_map();
      for (int i = 2; i < 8'h2e; i++) begin
         if (i == 8'h1e || i == 8'h1f) continue;
         io_host_model_i.wr(1'b0, 8'(i));
         io_host_model_i.wr(1'b1, 8'(i) ^ 8'ha5);
         io_host_model_i.wr(1'b0, 8'(i) | 8'h40);
         io_host_model_i.wr(1'b1, 8'(i) ^ 8'h5a);
      end
      for (int i = 2; i < 8'h2e; i++) begin
         if (i == 8'h1e || i == 8'h1f) continue;
         io_host_model_i.wr(1'b0, 8'(i));
         rd_chk(1'b1, 1'b0, {8'h00, 8'(i) ^ 8'ha5}, 2'b01, 16'h0000, 2'b00);
         io_host_model_i.wr(1'b0, 8'(i) | 8'h40);
         rd_chk(1'b1, 1'b0, {8'h00, 8'(i) ^ 8'h5a}, 2'b01, 16'h0000, 2'b00);
      end
   endtask
   // chip-wide bytes answer from either socket
   task automatic t_chip();
      io_host_model_i.wr(1'b0, 8'h5e);
      io_host_model_i.wr(1'b1, 8'h3c);
      io_host_model_i.wr(1'b0, 8'h1e);
      rd_chk(1'b1, 1'b0, 16'h003c, 2'b01, 16'h0000, 2'b00);
      io_host_model_i.wr(1'b0, 8'h40);
      rd_chk(1'b1, 1'b0, 16'h0011, 2'b01, 16'h0000, 2'b00);
      io_host_model_i.wr(1'b0, 8'h5f);
      rd_chk(1'b1, 1'b0, 16'h0022, 2'b01, 16'h0000, 2'b00);
   endtask
   // reserved bytes ignore writes and read zero
   task automatic t_reserved();
      logic [7:0] idx [4] = '{8'h01, 8'h2e, 8'h3f, 8'h41};
      foreach (idx[k]) begin
         io_host_model_i.wr(1'b0, idx[k]);
         io_host_model_i.wr(1'b1, 8'hff);
         rd_chk(1'b1, 1'b0, 16'h0000, 2'b01, 16'h0000, 2'b00);
      end
   endtask
   // second device answers only when the device bit names it
   task automatic t_device();
      io_host_model_i.wr(1'b0, 8'h82);
      io_host_model_i.wr(1'b1, 8'h6b);
      rd_chk(1'b1, 1'b0, 16'h0000, 2'b00, 16'h006b, 2'b01);
      rd_chk(1'b0, 1'b1, 16'h0082, 2'b01, 16'h6b00, 2'b10);
      io_host_model_i.wr(1'b0, 8'h02);
      rd_chk(1'b1, 1'b0, 16'h00a7, 2'b01, 16'h0000, 2'b00);
   endtask
   // dropping power good clears the pointer
   task automatic t_power();
      io_host_model_i.wr(1'b0, 8'h55);
      @(negedge clock);
      // release the write so it is not taken again once power returns
      io_host_model_i.idle();
      power_ok_input = 1'b0;
      @(negedge clock);
      power_ok_input = 1'b1;
      rd_chk(1'b0, 1'b0, 16'h0000, 2'b01, 16'h0000, 2'b00);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      rd_chk(1'b0, 1'b0, 16'h0000, 2'b01, 16'h0000, 2'b00);
      io_host_model_i.wr(1'b0, 8'h7f);
      rd_chk(1'b0, 1'b0, 16'h007f, 2'b01, 16'h0000, 2'b00);
      t_map();
      t_chip();
      t_reserved();
      t_device();
      t_power();
      test_done();
   end
endmodule // indexed_register_access_port_test

// [tb/io_host_model.sv]
// host processor model running i/o cycles on the pointer and window
`timescale 1ns/1ns
`include "index_port_defs.svh"
module io_host_model (
   input wire logic clock,
   output logic [9:0] io_addr,
   output logic io_read,
   output logic io_write,
   output logic io_wide,
   output logic [7:0] io_wdata
);
   // released bus shows inverted last values
   task automatic idle();
      io_read = 1'b0;
      io_write = 1'b0;
      io_wide = 1'b0;
      io_addr = ~io_addr;
      io_wdata = ~io_wdata;
   endtask
   task automatic wr(input logic win, input logic [7:0] d);
      @(negedge clock);
      io_addr = win ? `IDX_ADDR_WINDOW : `IDX_ADDR_POINTER;
      io_read = 1'b0;
      io_write = 1'b1;
      io_wdata = d;
      @(posedge clock);
   endtask
   // one-cycle read strobe, then release before the answer is looked at
   task automatic rd(input logic win, input logic wide);
      @(negedge clock);
      io_addr = win ? `IDX_ADDR_WINDOW : `IDX_ADDR_POINTER;
      io_write = 1'b0;
      io_read = 1'b1;
      io_wide = wide;
      @(posedge clock);
      @(negedge clock);
      idle();
   endtask
   initial begin
      io_addr = 10'h000;
      io_wdata = 8'h00;
      idle();
   end
endmodule // io_host_model
